/* File: rtl/gpenp_pkg.sv */
package gpenp_pkg;

  // Port geometry and timing.
  localparam int unsigned PINS            = 8;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned DEBOUNCE_MS     = 15;
  localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_MS * 1_000_000) / CLK_PERIOD_NS;

  // Field positions of the per-pin configuration register.
  localparam int unsigned CFG_OE_BIT    = 0;
  localparam int unsigned CFG_PP_BIT    = 1;
  localparam int unsigned CFG_PU_BIT    = 2;
  localparam int unsigned CFG_LOCK_BIT  = 3;
  localparam int unsigned CFG_LEVEL_BIT = 4;
  localparam int unsigned CFG_POL_BIT   = 5;
  localparam int unsigned CFG_DEB_BIT   = 6;

  // Field positions of the per-pin routing register.
  localparam int unsigned ROUTE_IRQ_BIT  = 0;
  localparam int unsigned ROUTE_MGMT_BIT = 1;
  localparam int unsigned ROUTE_PWR_BIT  = 2;

  // Masks and values after reset.
  localparam logic [7:0] CFG_RESET       = 8'h44;
  localparam logic [7:0] CFG_LOCKED_MASK = 8'h0f;
  localparam logic [7:0] CFG_EVENT_MASK  = 8'h70;
  localparam logic [7:0] CFG_USED_MASK   = 8'h7f;
  localparam logic [2:0] ROUTE_RESET     = 3'h1;
  localparam logic [7:0] LATCH_RESET     = 8'hff;
  localparam logic [7:0] ENABLE_RESET    = 8'h00;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [7:0] PIN_RESET       = 8'hff;

  // Configuration space offsets.
  localparam logic [1:0] CFG_ADDR_INDEX  = 2'h0;
  localparam logic [1:0] CFG_ADDR_PINCFG = 2'h1;
  localparam logic [1:0] CFG_ADDR_ROUTE  = 2'h2;

  // Runtime space offsets.
  localparam logic [1:0] RT_ADDR_LATCH  = 2'h0;
  localparam logic [1:0] RT_ADDR_LEVEL  = 2'h1;
  localparam logic [1:0] RT_ADDR_ENABLE = 2'h2;
  localparam logic [1:0] RT_ADDR_STATUS = 2'h3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } gpenp_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } gpenp_pad_t;

endpackage

/* File: rtl/gpenp_sync.sv */
module gpenp_sync #(
  parameter int unsigned     N       = 8,
  parameter logic [N-1:0]    RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous input and its synchronised copy
  input  wire logic [N-1:0] din,
  output logic      [N-1:0] dout
);

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
  } gpenp_sync_state_t;

  gpenp_sync_state_t q;
  gpenp_sync_state_t d;

  always_comb
  begin
    d      = q;
    d.meta = din;
    d.sync = q.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= {RST_VAL, RST_VAL};
    end
    else
    begin
      q <= d;
    end
  end

  assign dout = q.sync;

endmodule

/* File: rtl/gpenp_debounce.sv */
module gpenp_debounce #(
  parameter int unsigned  N       = 8,
  parameter int unsigned  CYCLES  = 1500000,
  parameter logic [N-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Raw and filtered levels
  input  wire logic [N-1:0] din,
  output logic      [N-1:0] dout
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [N-1:0]         lvl;
    logic [N-1:0][CW-1:0] cnt;
  } gpenp_deb_state_t;

  gpenp_deb_state_t q;
  gpenp_deb_state_t d;

  // A level is passed on only after it has differed from the output for a
  // whole quiet period; any bounce back restarts the count.
  always_comb
  begin
    d = q;
    for (int i = 0; i < int'(N); i++)
    begin
      if (din[i] == q.lvl[i])
      begin
        d.cnt[i] = '0; // RULE_01
      end
      else if (q.cnt[i] == LAST)
      begin
        d.lvl[i] = din[i]; // RULE_02
        d.cnt[i] = '0;
      end
      else
      begin
        d.cnt[i] = q.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '{lvl: RST_VAL, cnt: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign dout = q.lvl;

endmodule

/* File: rtl/gpenp_top.sv */
// How it works
// RULE_01: Debounced level passes after 15 ms quiet.
// RULE_02: Debounce delays pending rise and fall.
// RULE_03: Config bit 6 enables debouncer, reset on.
// RULE_04: Event enable bit gates system notification.
// RULE_05: Routing bits steer to IRQ, management, wake.
// RULE_06: Config bit 5 selects active polarity.
// RULE_07: Config bit 4 selects edge or level.
// RULE_08: Active edge sets status; write-1 clears.
// RULE_09: Pending means enabled and level or status.
// RULE_10: Output asserts when any routed pin pending.
// RULE_11: Inactive port clears status, blocks, detaches.
// RULE_12: Status clear releases edge; level persists.
// RULE_13: Software disables debounce for level events.
// RULE_14: Software configures, checks status, then enables.
// RULE_15: Enabled output level is the sensed input.
// RULE_16: Lock is set-only and freezes pin.
// RULE_17: Config bit 2 enables weak pull-up.
// RULE_18: Config bit 1 selects push-pull output.
// RULE_19: Config bit 0 enables output driver.
// RULE_20: Basic variant hides event bits and routing.
// RULE_21: Index register selects visible pin registers.
// RULE_22: Output latch drives pins, resets all ones.
// RULE_23: Pin inputs pass two synchronising flops.
module gpenp_top #(
  parameter bit          EVENTS_ON       = 1'b1,
  parameter int unsigned DEBOUNCE_CYCLES = gpenp_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 RESET_N,
  // Port activation
  input  wire logic                 PORT_ACTIVE,
  // Configuration space
  input  wire gpenp_pkg::gpenp_req_t CFG_REQ,
  output logic [7:0]                CFG_RDATA,
  output logic                      CFG_RVALID,
  // Runtime space
  input  wire gpenp_pkg::gpenp_req_t RT_REQ,
  output logic [7:0]                RT_RDATA,
  output logic                      RT_RVALID,
  // Pins
  input  wire logic [7:0]           GPIO_IN,
  output gpenp_pkg::gpenp_pad_t     GPIO_PAD,
  // System notification
  output logic                      IRQ_REQ,
  output logic                      MGMT_INT_REQ,
  output logic                      PWR_UP_REQ
);

  localparam int unsigned N = gpenp_pkg::PINS;
  // Bits that a configuration read may show; the basic variant hides the event fields.
  localparam logic [7:0] VIS_MASK = EVENTS_ON ? gpenp_pkg::CFG_USED_MASK
                                  : (gpenp_pkg::CFG_USED_MASK & ~gpenp_pkg::CFG_EVENT_MASK);

  typedef struct packed {
    logic [N-1:0][7:0] cfg;
    logic [N-1:0][2:0] route;
    logic [2:0]        sel;
    logic [N-1:0]      latch;
    logic [N-1:0]      enable;
    logic [N-1:0]      status;
    logic [N-1:0]      prev;
    logic              irq;
    logic              mgmt;
    logic              pwr;
    gpenp_pkg::gpenp_pad_t pad;
    logic [7:0]        cfg_rdata;
    logic              cfg_rvalid;
    logic [7:0]        rt_rdata;
    logic              rt_rvalid;
  } gpenp_state_t;

  gpenp_state_t q;
  gpenp_state_t d;

  logic [1:0]   rst_q;
  logic         rst_n;
  logic [N-1:0] pin_s;
  logic [N-1:0] deb_lvl;
  logic [N-1:0] oe_v;
  logic [N-1:0] pp_v;
  logic [N-1:0] pu_v;
  logic [N-1:0] lock_v;
  logic [N-1:0] ltype_v;
  logic [N-1:0] pol_v;
  logic [N-1:0] deb_v;
  logic [N-1:0] r_irq_v;
  logic [N-1:0] r_mgmt_v;
  logic [N-1:0] r_pwr_v;
  logic [N-1:0] drive_v;
  logic [N-1:0] sense_v;
  logic [N-1:0] lvl_v;
  logic [N-1:0] act_v;
  logic [N-1:0] edge_v;
  logic [N-1:0] pend_v;

  // Reset is released through two flops so that every register leaves
  // reset on the same edge.
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_q <= 2'h0;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // Pins idle high behind the default pull-ups, so the chain resets high
  // to avoid a false falling edge after reset.
  gpenp_sync #(
    .N       (N),
    .RST_VAL (gpenp_pkg::PIN_RESET)
  ) u_sync (
    .clk  (MCLK),
    .rst_n(rst_n),
    .din  (GPIO_IN), // RULE_23
    .dout (pin_s)
  );

  // The debouncer sees the sensed level, so a driving pin is filtered like any other.
  gpenp_debounce #(
    .N       (N),
    .CYCLES  (DEBOUNCE_CYCLES),
    .RST_VAL (gpenp_pkg::PIN_RESET)
  ) u_deb (
    .clk  (MCLK),
    .rst_n(rst_n),
    .din  (sense_v),
    .dout (deb_lvl)
  );

  // Per-pin decode of the configuration. In the basic variant the event fields and the
  // routing are forced to zero, so whatever software wrote there has no effect.
  genvar g;
  generate
    for (g = 0; g < int'(N); g++)
    begin : g_pin
      assign oe_v[g]    = q.cfg[g][gpenp_pkg::CFG_OE_BIT];
      assign pp_v[g]    = q.cfg[g][gpenp_pkg::CFG_PP_BIT];
      assign pu_v[g]    = q.cfg[g][gpenp_pkg::CFG_PU_BIT];
      assign lock_v[g]  = q.cfg[g][gpenp_pkg::CFG_LOCK_BIT];
      assign ltype_v[g] = EVENTS_ON & q.cfg[g][gpenp_pkg::CFG_LEVEL_BIT]; // RULE_07 RULE_20
      assign pol_v[g]   = EVENTS_ON & q.cfg[g][gpenp_pkg::CFG_POL_BIT]; // RULE_06 RULE_20
      assign deb_v[g]   = EVENTS_ON & q.cfg[g][gpenp_pkg::CFG_DEB_BIT]; // RULE_03 RULE_20
      assign r_irq_v[g] = EVENTS_ON & q.route[g][gpenp_pkg::ROUTE_IRQ_BIT]; // RULE_05
      assign r_mgmt_v[g] = EVENTS_ON & q.route[g][gpenp_pkg::ROUTE_MGMT_BIT]; // RULE_05
      assign r_pwr_v[g] = EVENTS_ON & q.route[g][gpenp_pkg::ROUTE_PWR_BIT]; // RULE_05
      // An open-drain pin that holds a one is released and reads the wire.
      assign drive_v[g] = oe_v[g] & (pp_v[g] | ~q.latch[g]); // RULE_18 RULE_19
      assign sense_v[g] = drive_v[g] ? q.latch[g] : pin_s[g]; // RULE_15
      assign lvl_v[g]   = deb_v[g] ? deb_lvl[g] : sense_v[g]; // RULE_03
      assign act_v[g]   = ~(lvl_v[g] ^ pol_v[g]); // RULE_06
      assign edge_v[g]  = pol_v[g] ? (lvl_v[g] & ~q.prev[g])
                                   : (~lvl_v[g] & q.prev[g]); // RULE_06 RULE_08
      assign pend_v[g]  = q.enable[g] & (ltype_v[g] ? act_v[g]
                                                    : q.status[g]); // RULE_09 RULE_12
    end
  endgenerate

  always_comb
  begin
    logic [7:0]   cur;
    logic [7:0]   frz;
    logic [7:0]   nxt;
    logic [N-1:0] clr;
    cur = q.cfg[q.sel];
    frz = '0;
    nxt = '0;
    clr = '0;
    d   = q;

    d.cfg_rvalid = 1'b0;
    d.rt_rvalid  = 1'b0;
    // The edge detector watches lvl_v, the debounced level only while config bit 6 is set, so only then does a bounce set nothing.
    d.prev       = lvl_v;

    // Configuration space, always reachable.
    if (CFG_REQ.wr)
    begin
      case (CFG_REQ.addr)
        gpenp_pkg::CFG_ADDR_INDEX:
        begin
          d.sel = CFG_REQ.wdata[2:0]; // RULE_21
        end
        gpenp_pkg::CFG_ADDR_PINCFG:
        begin
          // Software can only raise the lock; nothing but a reset lowers it again.
          frz = cur[gpenp_pkg::CFG_LOCK_BIT] ? gpenp_pkg::CFG_LOCKED_MASK : 8'h00; // RULE_16
          nxt = ((CFG_REQ.wdata & ~frz) | (cur & frz)) & gpenp_pkg::CFG_USED_MASK;
          nxt[gpenp_pkg::CFG_LOCK_BIT] = cur[gpenp_pkg::CFG_LOCK_BIT]
                                       | CFG_REQ.wdata[gpenp_pkg::CFG_LOCK_BIT]; // RULE_16
          d.cfg[q.sel] = nxt; // RULE_21
        end
        gpenp_pkg::CFG_ADDR_ROUTE:
        begin
          d.route[q.sel] = CFG_REQ.wdata[2:0]; // RULE_05 RULE_21
        end
        default:
        begin
        end
      endcase
    end

    if (CFG_REQ.rd)
    begin
      d.cfg_rvalid = 1'b1;
      case (CFG_REQ.addr)
        gpenp_pkg::CFG_ADDR_INDEX:
        begin
          d.cfg_rdata = {5'h00, q.sel}; // RULE_21
        end
        gpenp_pkg::CFG_ADDR_PINCFG:
        begin
          d.cfg_rdata = cur & VIS_MASK; // RULE_20
        end
        gpenp_pkg::CFG_ADDR_ROUTE:
        begin
          // The basic variant has no routing, so the whole register reads zero.
          d.cfg_rdata = EVENTS_ON ? {5'h00, q.route[q.sel]} : 8'h00; // RULE_20
        end
        default:
        begin
          d.cfg_rdata = 8'h00;
        end
      endcase
    end

    // Runtime space; an inactive port ignores writes and reads back zero.
    if (RT_REQ.wr && PORT_ACTIVE)
    begin
      case (RT_REQ.addr)
        gpenp_pkg::RT_ADDR_LATCH:
        begin
          for (int i = 0; i < int'(N); i++)
          begin
            if (!lock_v[i])
            begin
              d.latch[i] = RT_REQ.wdata[i]; // RULE_16 RULE_22
            end
          end
        end
        gpenp_pkg::RT_ADDR_ENABLE:
        begin
          d.enable = RT_REQ.wdata; // RULE_04
        end
        gpenp_pkg::RT_ADDR_STATUS:
        begin
          clr = RT_REQ.wdata; // RULE_08
        end
        default:
        begin
        end
      endcase
    end

    if (RT_REQ.rd)
    begin
      d.rt_rvalid = 1'b1;
      d.rt_rdata  = 8'h00; // RULE_11
      if (PORT_ACTIVE)
      begin
        case (RT_REQ.addr)
          gpenp_pkg::RT_ADDR_LATCH:
          begin
            d.rt_rdata = q.latch; // RULE_22
          end
          gpenp_pkg::RT_ADDR_LEVEL:
          begin
            // A driving pin shows what it drives, so software reads back its own write.
            d.rt_rdata = sense_v; // RULE_15
          end
          gpenp_pkg::RT_ADDR_ENABLE:
          begin
            d.rt_rdata = q.enable; // RULE_04
          end
          gpenp_pkg::RT_ADDR_STATUS:
          begin
            d.rt_rdata = q.status; // RULE_08
          end
          default:
          begin
            d.rt_rdata = 8'h00;
          end
        endcase
      end
    end

    // An edge in the same cycle as a write-one clear keeps the bit set.
    d.status = (q.status & ~clr) | edge_v; // RULE_08 RULE_12
    if (!PORT_ACTIVE)
    begin
      d.status = gpenp_pkg::STATUS_RESET; // RULE_11
    end

    // Notifications are levels that fall as soon as the last routed source stops pending.
    d.irq  = PORT_ACTIVE & |(pend_v & r_irq_v); // RULE_10 RULE_11 RULE_04
    d.mgmt = PORT_ACTIVE & |(pend_v & r_mgmt_v); // RULE_10 RULE_11
    d.pwr = PORT_ACTIVE & |(pend_v & r_pwr_v); // RULE_10 RULE_11

    // Deactivation leaves the pins as they are.
    d.pad.out = q.latch; // RULE_22
    d.pad.oe  = drive_v; // RULE_18 RULE_19
    d.pad.pu  = pu_v; // RULE_17
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Pins start as inputs with pull-ups on, so nothing is driven until software asks.
      q            <= '0;
      q.cfg        <= {N{gpenp_pkg::CFG_RESET}};
      q.route      <= {N{gpenp_pkg::ROUTE_RESET}};
      q.latch      <= gpenp_pkg::LATCH_RESET;
      q.enable     <= gpenp_pkg::ENABLE_RESET;
      q.status     <= gpenp_pkg::STATUS_RESET;
      q.prev       <= gpenp_pkg::PIN_RESET;
      q.pad.out    <= gpenp_pkg::LATCH_RESET;
      q.pad.pu     <= gpenp_pkg::PIN_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign CFG_RDATA  = q.cfg_rdata;
  assign CFG_RVALID = q.cfg_rvalid;
  assign RT_RDATA   = q.rt_rdata;
  assign RT_RVALID  = q.rt_rvalid;
  assign GPIO_PAD   = q.pad;
  assign IRQ_REQ    = q.irq;
  assign MGMT_INT_REQ = q.mgmt;
  assign PWR_UP_REQ = q.pwr;

endmodule

/* File: verif/gpenp_pins.sv */
module gpenp_pins (
  // Clock for the float pattern
  input  wire logic                  clk,
  // Pad controls and external drive
  input  wire gpenp_pkg::gpenp_pad_t pad,
  input  wire logic [7:0]            drv,
  input  wire logic [7:0]            ext,
  // Resolved pin levels
  output logic      [7:0]            lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] alt = 8'h55;
  // An undriven pin without pull-up toggles, so it never passes for a settled level.
  always @(posedge clk)
    alt <= ~alt;
  assign lvl = (pad.oe & pad.out) | (~pad.oe & drv & ext)
             | (~pad.oe & ~drv & (pad.pu | alt));
endmodule

/* File: verif/gpenp_top_props.sv */
module gpenp_top_props #(
  parameter bit          EVENTS_ON       = 1'b1,
  parameter int unsigned DEBOUNCE_CYCLES = 8
) (
  // Clock and reset
  input wire logic                  MCLK,
  input wire logic                  RESET_N,
  // Register access
  input wire logic                  PORT_ACTIVE,
  input wire gpenp_pkg::gpenp_req_t CFG_REQ,
  input wire logic [7:0]            CFG_RDATA,
  input wire logic                  CFG_RVALID,
  input wire gpenp_pkg::gpenp_req_t RT_REQ,
  input wire logic [7:0]            RT_RDATA,
  input wire logic                  RT_RVALID,
  // Notification
  input wire logic                  IRQ_REQ,
  input wire logic                  MGMT_INT_REQ,
  input wire logic                  PWR_UP_REQ
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  wire logic [2:0] note = {IRQ_REQ, MGMT_INT_REQ, PWR_UP_REQ};

  cfg_answer_a: assert property (CFG_REQ.rd |=> CFG_RVALID)
    else $error("config read not answered");
  rt_answer_a: assert property (RT_REQ.rd |=> RT_RVALID)
    else $error("runtime read not answered");
  answer_cause_a: assert property ((CFG_RVALID |-> $past(CFG_REQ.rd))
    and (RT_RVALID |-> $past(RT_REQ.rd))) else $error("answer without read");
  off_quiet_a: assert property (!PORT_ACTIVE && $past(!PORT_ACTIVE) |-> note == 3'h0)
    else $error("notification while port inactive");
  off_read_a: assert property (RT_REQ.rd && !PORT_ACTIVE |=> RT_RDATA == 8'h00)
    else $error("runtime read while inactive not zero");
  cfg_hole_a: assert property (CFG_REQ.rd && CFG_REQ.addr == 2'h3 |=> CFG_RDATA == 8'h00)
    else $error("unmapped config read not zero");
  route_rsvd_a: assert property (CFG_REQ.rd && CFG_REQ.addr == 2'h2 |=>
    CFG_RDATA[7:3] == 5'h00 && (EVENTS_ON || CFG_RDATA == 8'h00)) else $error("routing reserved");
  cfg_rsvd_a: assert property (CFG_REQ.rd && CFG_REQ.addr == 2'h1 |=>
    !CFG_RDATA[7] && (EVENTS_ON || CFG_RDATA[6:4] == 3'h0)) else $error("config reserved");
  note_rise_a: assert property ($rose(|note) |-> $past(PORT_ACTIVE))
    else $error("notification rose on inactive port");

  cover property ($rose(IRQ_REQ));
  cover property ($rose(MGMT_INT_REQ));
  cover property ($rose(PWR_UP_REQ));
  cover property (!PORT_ACTIVE && RT_REQ.rd);
endmodule

bind gpenp_top gpenp_top_props #(.EVENTS_ON(EVENTS_ON), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (
  .MCLK, .RESET_N, .PORT_ACTIVE, .CFG_REQ, .CFG_RDATA, .CFG_RVALID,
  .RT_REQ, .RT_RDATA, .RT_RVALID, .IRQ_REQ, .MGMT_INT_REQ, .PWR_UP_REQ);

/* File: verif/gpenp_top_tb.sv */
module gpenp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DB = 8;
  logic                  mclk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  pa = 1'b1;
  gpenp_pkg::gpenp_req_t cq = '0;
  gpenp_pkg::gpenp_req_t rq = '0;
  gpenp_pkg::gpenp_pad_t pad;
  logic [7:0]            xv = 8'hff;
  logic [7:0]            lvl, crd, rrd;
  logic                  cv, rv, irq, mgmt, pwr;
  logic [7:0]            crd_b;
  logic                  cv_b, irq_b, mgmt_b, pwr_b;
  int                    failures = 0;
  int                    comparisons = 0;

  gpenp_top #(.EVENTS_ON(1'b1), .DEBOUNCE_CYCLES(DB)) dut (
    .MCLK(mclk), .RESET_N(reset_n), .PORT_ACTIVE(pa), .CFG_REQ(cq), .CFG_RDATA(crd),
    .CFG_RVALID(cv), .RT_REQ(rq), .RT_RDATA(rrd), .RT_RVALID(rv), .GPIO_IN(lvl),
    .GPIO_PAD(pad), .IRQ_REQ(irq), .MGMT_INT_REQ(mgmt), .PWR_UP_REQ(pwr));
  // The basic variant shares every input and must hide the event fields.
  gpenp_top #(.EVENTS_ON(1'b0), .DEBOUNCE_CYCLES(DB)) dut_basic (
    .MCLK(mclk), .RESET_N(reset_n), .PORT_ACTIVE(pa), .CFG_REQ(cq), .CFG_RDATA(crd_b),
    .CFG_RVALID(cv_b), .RT_REQ(rq), .RT_RDATA(), .RT_RVALID(), .GPIO_IN(lvl),
    .GPIO_PAD(), .IRQ_REQ(irq_b), .MGMT_INT_REQ(mgmt_b), .PWR_UP_REQ(pwr_b));
  gpenp_pins u_pins (.clk(mclk), .pad(pad), .drv(8'hff), .ext(xv), .lvl(lvl));

  always #5 mclk = ~mclk;

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string n, logic [23:0] s, logic [23:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(bit s, logic [1:0] a, logic [7:0] d);
    @(posedge mclk);
    if (s)
      rq <= '{1'b1, 1'b0, a, d};
    else
      cq <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    rq <= '0;
    cq <= '0;
  endtask

  task automatic rd(bit s, logic [1:0] a, logic [7:0] e, string n);
    @(posedge mclk);
    if (s)
      rq <= '{1'b0, 1'b1, a, 8'h00};
    else
      cq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    rq <= '0;
    cq <= '0;
    #1;
    chk(n, s ? {rv, rrd} : {cv, crd}, {1'b1, e});
  endtask

  task automatic pin(logic [7:0] v);
    @(posedge mclk);
    xv <= v;
  endtask

  // Waits for the notification outputs; a wait that runs out ends the run.
  task automatic wn(logic [2:0] e);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge mclk);
      #1;
      if ({irq, mgmt, pwr} === e)
        break;
    end
    chk("notify", {irq, mgmt, pwr}, e);
    if (i == 40)
      complete_run();
  endtask

  task automatic s_reset();
    chk("pad", pad, 24'hff00ff);
    rd(0, 1, 8'h44, "cfg");
    chk("basic cfg", {cv_b, crd_b}, {1'b1, 8'h04});
    rd(0, 2, 8'h01, "route");
    chk("basic route", {cv_b, crd_b}, {1'b1, 8'h00});
    rd(0, 3, 8'h00, "hole");
    rd(1, 0, 8'hff, "latch");
    rd(1, 2, 8'h00, "enable");
    rd(1, 3, 8'h00, "status");
  endtask

  task automatic s_edge();
    wr(0, 0, 8'h00);
    wr(0, 1, 8'h00);
    wr(1, 3, 8'hff);
    wr(1, 2, 8'h01);
    pin(8'hfe);
    wn(3'b100);
    wr(1, 3, 8'h00);
    rd(1, 3, 8'h01, "status");
    wr(1, 3, 8'h01);
    wn(3'b000);
    for (int k = 0; k < 3; k++)
    begin
      wr(0, 2, 8'h01 << k);
      pin(8'hff);
      repeat (5) @(posedge mclk);
      rd(1, 3, 8'h00, "status");
      pin(8'hfe);
      wn(3'b100 >> k);
      wr(1, 3, 8'h01);
      wn(3'b000);
    end
  endtask

  task automatic s_level();
    wr(0, 0, 8'h01);
    wr(0, 1, 8'h30);
    wr(1, 3, 8'hff);
    wr(1, 2, 8'h02);
    wn(3'b100);
    chk("basic notify", {irq_b, mgmt_b, pwr_b}, 3'h0);
    wr(1, 3, 8'hff);
    repeat (3) @(posedge mclk);
    wn(3'b100);
    pin(8'hfc);
    wn(3'b000);
    pin(8'hfe);
    wn(3'b100);
    wr(1, 2, 8'h00);
    wn(3'b000);
  endtask

  task automatic s_debounce();
    wr(0, 0, 8'h02);
    wr(0, 1, 8'h40);
    wr(1, 3, 8'hff);
    pin(8'hfa);
    repeat (3) @(posedge mclk);
    pin(8'hfe);
    repeat (20) @(posedge mclk);
    rd(1, 3, 8'h00, "status");
    pin(8'hfa);
    repeat (6) @(posedge mclk);
    rd(1, 3, 8'h00, "status");
    repeat (10) @(posedge mclk);
    rd(1, 3, 8'h04, "status");
  endtask

  task automatic s_lock();
    wr(0, 0, 8'h03);
    wr(0, 1, 8'h0b);
    wr(0, 1, 8'h00);
    rd(0, 1, 8'h0b, "cfg");
    wr(0, 0, 8'h04);
    wr(0, 1, 8'h03);
    wr(1, 3, 8'hff);
    wr(1, 0, 8'h00);
    repeat (6) @(posedge mclk);
    rd(1, 0, 8'h08, "latch");
    rd(1, 1, 8'hea, "level");
    rd(1, 3, 8'h10, "status");
    chk("pad", pad, 24'h0818e0);
  endtask

  task automatic s_off();
    wr(1, 2, 8'h10);
    wn(3'b100);
    @(posedge mclk);
    pa <= 1'b0;
    repeat (2) @(posedge mclk);
    wn(3'b000);
    rd(1, 3, 8'h00, "status");
    rd(1, 2, 8'h00, "enable");
    @(posedge mclk);
    pa <= 1'b1;
    rd(1, 3, 8'h00, "status");
  endtask

  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    s_reset();
    s_edge();
    s_level();
    s_debounce();
    s_lock();
    s_off();
    complete_run();
  end
endmodule
